/* design/pin_mux_pkg.sv */
// Purpose: constants and carriers for the port pin function mux
// Assumes: 10 MHz system clock, pins sampled synchronously
// Notes:   pin triplets are input, output, output enable
package pin_mux_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned RST_MIN_LOW_NS  = 100;
  // least time rounds up
  localparam int unsigned RST_MIN_CYCLES_RAW =
    (RST_MIN_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RST_MIN_CYCLES =
    (RST_MIN_CYCLES_RAW < 1) ? 1 : RST_MIN_CYCLES_RAW;
  localparam int unsigned RST_CNT_W = 8;
  localparam int unsigned DEBUG_CNT_W = 4;

  // port B pin zero function select
  localparam logic [1:0] PB0_SEL_GPIO   = 2'h0;
  localparam logic [1:0] PB0_SEL_TIMER  = 2'h1;
  localparam logic [1:0] PB0_SEL_ANALOG = 2'h2;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } pin_type;

  typedef struct packed {
    logic dir_out;
    logic data_out;
    logic pull_en;
  } gpio_cfg_type;
endpackage : pin_mux_pkg

/* design/port_pin_function_mux.sv */
// Purpose: reset pin filtering and port A/B pin function routing
// Assumes: all pin inputs synchronous to clk_sys_i
// Notes:   pulldown/pullup enables are outputs to the pad cells
module port_pin_function_mux #(
  parameter int unsigned RST_MIN_CYCLES = pin_mux_pkg::RST_MIN_CYCLES
) (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rstn_i,
  // reset pin
  input  wire logic                     reset_pin_n_i,
  output logic                          ext_reset_req_o,
  output logic                          cpu_fetch_vector_o,
  output logic                          debug_entry_o,
  // port B pin zero
  input  wire logic                     port_b_pin_zero_i,
  output logic                          port_b_pin_zero_o,
  output logic                          port_b_pin_zero_oe_o,
  output logic                          port_b_pin_zero_pullup_o,
  input  wire logic [1:0]               pb0_func_sel_i,
  input  wire pin_mux_pkg::gpio_cfg_type pb0_cfg_i,
  output logic                          pb0_gpio_in_o,
  input  wire logic                     timer_channel_zero_out_i,
  input  wire logic                     timer_channel_zero_oe_i,
  output logic                          timer_channel_zero_in_o,
  output logic                          analog_input_three_sel_o,
  // port A pins one to three, index = pin number
  input  wire logic [3:1]               port_a_pin_i,
  output logic      [3:1]               port_a_pin_o,
  output logic      [3:1]               port_a_pin_oe_o,
  output logic      [3:1]               port_a_pin_pulldown_o,
  output logic      [3:1]               port_a_pin_pullup_o,
  input  wire logic [3:1]               pa_dir_out_i,
  input  wire logic [3:1]               pa_data_out_i,
  input  wire logic [3:1]               pa_pull_en_i,
  input  wire logic [3:1]               pa_pull_down_sel_i,
  input  wire logic [3:1]               wakeup_en_i,
  output logic      [3:1]               pa_gpio_in_o,
  output logic      [3:1]               keyboard_wakeup_interrupt_o,
  // client spi
  input  wire logic                     spi_en_i,
  input  wire logic                     port_a_pin_zero_i,
  input  wire logic                     spi_miso_i,
  output logic                          spi_mosi_o,
  output logic                          spi_sclk_o,
  output logic                          spi_ss_n_o
);
  // the low-time counter must be able to reach the threshold
  if (RST_MIN_CYCLES < 1 || RST_MIN_CYCLES >= (1 << pin_mux_pkg::RST_CNT_W)) begin : g_bad_min
    $error("RST_MIN_CYCLES out of range");
  end

  // reset pin low-time filter
  logic [pin_mux_pkg::RST_CNT_W-1:0] low_cnt_r;
  logic                              low_ok_r;
  logic                              pin_prev_r;
  wire                               rise = reset_pin_n_i && !pin_prev_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // idle level of the pin, so release gives no false rise
      pin_prev_r <= 1'b1;
    end else begin
      pin_prev_r <= reset_pin_n_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_r <= '0;
      low_ok_r  <= 1'b0;
    end else if (reset_pin_n_i) begin
      low_cnt_r <= '0;
      low_ok_r  <= 1'b0;
    end else begin
      if (!low_ok_r)
        low_cnt_r <= low_cnt_r + 1'b1;
      if (low_cnt_r + 1'b1 >= RST_MIN_CYCLES[pin_mux_pkg::RST_CNT_W-1:0])
        low_ok_r <= 1'b1;
    end
  end

  a_short_low_ign: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (rise && !low_ok_r) |=> !cpu_fetch_vector_o)
    else $error("short low pulse gave a vector fetch");
  a_filter_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reset_pin_n_i |=> !low_ok_r)
    else $error("low qualification kept after pin high");

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_reset_req_o    <= 1'b0;
      cpu_fetch_vector_o <= 1'b0;
    end else begin
      ext_reset_req_o    <= low_ok_r && !reset_pin_n_i;
      cpu_fetch_vector_o <= rise && low_ok_r;
    end
  end

  a_vector_fetch: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (rise && low_ok_r) |=> cpu_fetch_vector_o)
    else $error("no vector fetch after reset release");
  a_reset_req: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ext_reset_req_o |-> $past(reset_pin_n_i) == 1'b0)
    else $error("reset request without low pin");
  a_fetch_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cpu_fetch_vector_o |=> !cpu_fetch_vector_o)
    else $error("vector fetch longer than one cycle");
  c_ext_reset: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cpu_fetch_vector_o);

  // debug entry on qualified release
  // port B pin zero held low as input marks the debug request
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_entry_o <= 1'b0;
    end else begin
      debug_entry_o <= 1'b0;
      if (rise && low_ok_r) begin
        if (!port_b_pin_zero_i && !pb0_cfg_i.dir_out)
          debug_entry_o <= 1'b1;
      end
    end
  end

  a_debug_entry: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    debug_entry_o |-> $past(low_ok_r))
    else $error("debug entry without qualified reset");
  c_debug: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) debug_entry_o);

  always_comb begin
    port_b_pin_zero_o        = pb0_cfg_i.data_out;
    port_b_pin_zero_oe_o     = pb0_cfg_i.dir_out;
    port_b_pin_zero_pullup_o = pb0_cfg_i.pull_en && !pb0_cfg_i.dir_out;
    analog_input_three_sel_o = 1'b0;
    unique case (pb0_func_sel_i)
      pin_mux_pkg::PB0_SEL_GPIO: ;
      pin_mux_pkg::PB0_SEL_TIMER: begin
        port_b_pin_zero_o    = timer_channel_zero_out_i;
        port_b_pin_zero_oe_o = timer_channel_zero_oe_i;
      end
      pin_mux_pkg::PB0_SEL_ANALOG: begin
        port_b_pin_zero_o        = 1'b0;
        port_b_pin_zero_oe_o     = 1'b0;
        port_b_pin_zero_pullup_o = 1'b0;
        analog_input_three_sel_o = 1'b1;
      end
      // reserved code 3 acts as gpio
      default: ;
    endcase
  end
  assign pb0_gpio_in_o           = port_b_pin_zero_i;
  assign timer_channel_zero_in_o = port_b_pin_zero_i;

  a_pb0_analog: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    analog_input_three_sel_o |-> !port_b_pin_zero_oe_o)
    else $error("analog pin driven");
  a_pb0_pullup: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    port_b_pin_zero_pullup_o |-> pb0_cfg_i.pull_en && !analog_input_three_sel_o)
    else $error("port B pullup on without enable");
  c_analog: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    analog_input_three_sel_o);

  // port A pins one to three
  for (genvar i = 1; i <= 3; i++) begin : g_pa
    wire gpio_oe = pa_dir_out_i[i];
    // pulls off while driving, they would only burn current
    // pulldown gated by wake-up
    assign port_a_pin_pulldown_o[i] = !spi_en_i && !gpio_oe && pa_pull_en_i[i]
                                      && pa_pull_down_sel_i[i] && wakeup_en_i[i];
    assign port_a_pin_pullup_o[i]   = !spi_en_i && !gpio_oe && pa_pull_en_i[i]
                                      && !pa_pull_down_sel_i[i];
    // wake-up bit i from pin i
    assign keyboard_wakeup_interrupt_o[i] = !spi_en_i && wakeup_en_i[i] && port_a_pin_i[i];
    assign pa_gpio_in_o[i] = port_a_pin_i[i];
  end

  a_pulldown_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (port_a_pin_pulldown_o & ~wakeup_en_i) == 3'h0)
    else $error("pulldown on without wake-up enable");
  a_wakeup_map: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !spi_en_i |-> keyboard_wakeup_interrupt_o == (wakeup_en_i & port_a_pin_i))
    else $error("wake-up bit not fed by its pin");
  c_wakeup: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    |keyboard_wakeup_interrupt_o);

  // in spi mode pins one and three stay inputs so the host owns them
  // pin two drives MISO in spi mode
  always_comb begin
    port_a_pin_o    = pa_data_out_i;
    port_a_pin_oe_o = pa_dir_out_i;
    if (spi_en_i) begin
      port_a_pin_o    = {1'b0, spi_miso_i, 1'b0};
      port_a_pin_oe_o = {1'b0, 1'b1, 1'b0};
    end
  end

  a_miso_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    spi_en_i |-> port_a_pin_oe_o[2] && port_a_pin_o[2] == spi_miso_i)
    else $error("miso not driven on pin two");
  a_gpio_return: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !spi_en_i |-> port_a_pin_oe_o == pa_dir_out_i && port_a_pin_o == pa_data_out_i)
    else $error("gpio not restored");

  assign spi_mosi_o = spi_en_i ? port_a_pin_i[3] : 1'b0;
  assign spi_sclk_o = spi_en_i ? port_a_pin_i[1] : 1'b0;
  assign spi_ss_n_o = spi_en_i ? port_a_pin_zero_i : 1'b1;

  a_mosi_route: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    spi_en_i |-> spi_mosi_o == port_a_pin_i[3] && !port_a_pin_oe_o[3])
    else $error("mosi not taken from pin three");
  a_sclk_ss: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    spi_en_i |-> spi_sclk_o == port_a_pin_i[1] && spi_ss_n_o == port_a_pin_zero_i)
    else $error("sclk or select not routed");
  a_spi_pulls_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    spi_en_i |-> (port_a_pin_pullup_o | port_a_pin_pulldown_o) == 3'h0)
    else $error("pull device on in spi mode");
  a_spi_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !spi_en_i |-> spi_ss_n_o && !spi_sclk_o && !spi_mosi_o)
    else $error("spi inputs not idle with spi off");
  c_spi_mode: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(spi_en_i));
endmodule : port_pin_function_mux

/* sim/pin_board_model.sv */
// Purpose: board side of the muxed pins
// Assumes: bit 0 is port B pin zero, bits 3:1 port A
// Notes:   an unheld pin without pull toggles each cycle
module pin_board_model (
  // clock
  input  wire logic       clk_sys_i,
  // device side
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] out_i,
  input  wire logic [3:0] pu_i,
  input  wire logic [3:0] pd_i,
  // board drive
  input  wire logic [3:0] ext_en_i,
  input  wire logic [3:0] ext_val_i,
  output logic      [3:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] float_r = 4'h5;
  always_ff @(posedge clk_sys_i) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                   pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : float_r[i];
    end
  end
endmodule : pin_board_model

/* sim/port_pin_function_mux_tb.sv */
// Purpose: directed test of the pin function mux
// Assumes: comb paths settle by the falling edge
// Notes:   default reset filter of one cycle
module port_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, rpin = 1'b1, spi = 1'b0, pa0 = 1'b1, miso = 1'b0;
  logic [1:0] sel = 2'h0;
  logic t_out = 1'b0, t_oe = 1'b0;
  logic [2:0] pdir = 3'h0, pdat = 3'h0, pen = 3'h0, pds = 3'h0, wk = 3'h0;
  logic [3:0] ext_en = 4'h0, ext_val = 4'h0, nf, nd;
  pin_mux_pkg::gpio_cfg_type cfg = '0;
  wire [3:0] lvl, dout, doe, pu, pd, gin;
  wire [2:0] wake, so;
  wire req, fetch, dbg, t_in, an;
  int err_count = 0, num_checks = 0, cyc = 0;
  logic [4:0] exp_pb [3] = '{5'h0B, 5'h08, 5'h12};
  assign pd[0] = 1'b0;
  initial forever #50 clk_sys_i = ~clk_sys_i;
  port_pin_function_mux i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reset_pin_n_i(rpin),
    .ext_reset_req_o(req), .cpu_fetch_vector_o(fetch), .debug_entry_o(dbg),
    .port_b_pin_zero_i(lvl[0]), .port_b_pin_zero_o(dout[0]), .port_b_pin_zero_oe_o(doe[0]),
    .port_b_pin_zero_pullup_o(pu[0]), .pb0_func_sel_i(sel), .pb0_cfg_i(cfg),
    .pb0_gpio_in_o(gin[0]), .timer_channel_zero_out_i(t_out), .timer_channel_zero_oe_i(t_oe),
    .timer_channel_zero_in_o(t_in), .analog_input_three_sel_o(an), .port_a_pin_i(lvl[3:1]),
    .port_a_pin_o(dout[3:1]), .port_a_pin_oe_o(doe[3:1]), .port_a_pin_pulldown_o(pd[3:1]),
    .port_a_pin_pullup_o(pu[3:1]), .pa_dir_out_i(pdir), .pa_data_out_i(pdat),
    .pa_pull_en_i(pen), .pa_pull_down_sel_i(pds), .wakeup_en_i(wk), .pa_gpio_in_o(gin[3:1]),
    .keyboard_wakeup_interrupt_o(wake), .spi_en_i(spi), .port_a_pin_zero_i(pa0),
    .spi_miso_i(miso), .spi_mosi_o(so[2]), .spi_sclk_o(so[1]), .spi_ss_n_o(so[0]));
  pin_board_model i_board (.clk_sys_i(clk_sys_i), .oe_i(doe), .out_i(dout), .pu_i(pu),
    .pd_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // hang guard, run needs about 30 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 500) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    ext_en <= 4'h1;
    rpin <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(req, 1);
    @(posedge clk_sys_i);
    rpin <= 1'b1;
    nf = 0;
    nd = 0;
    repeat (4) begin
      @(negedge clk_sys_i);
      nf += fetch;
      nd += dbg;
    end
    chk({req, nf}, 1);
    chk(nd, 1);
    $display("test reset pin done");
    for (int s = 0; s < 3; s++) begin
      @(posedge clk_sys_i);
      sel <= 2'(s);
      cfg <= 3'h7;
      t_oe <= 1'b1;
      ext_val <= 4'h1;
      @(negedge clk_sys_i);
      chk({an, doe[0], pu[0], gin[0], dout[0]}, exp_pb[s]);
    end
    @(posedge clk_sys_i);
    sel <= 2'h0;
    cfg <= 3'h1;
    @(negedge clk_sys_i);
    chk({pu[0], doe[0], t_in}, 3'h5);
    $display("test port B done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      wk <= 3'(k);
      pen <= 3'h7;
      pds <= 3'(k ^ 3);
      ext_en <= 4'hE;
      ext_val <= 4'hC;
      @(negedge clk_sys_i);
      chk({pu[3:1], pd[3:1]}, {~(k[2:0] ^ 3'h3), k[2:0] & (k[2:0] ^ 3'h3)});
      chk(wake, k & 6);
      chk(gin[3:1], 3'h6);
    end
    $display("test wake-up done");
    for (int v = 0; v < 4; v++) begin
      @(posedge clk_sys_i);
      spi <= 1'b1;
      pdir <= 3'h7;
      ext_en <= 4'hA;
      ext_val <= {v[1], 1'b0, v[0], 1'b0};
      miso <= v[0];
      pa0 <= v[1];
      @(negedge clk_sys_i);
      chk({so, doe[3:1], lvl[2]}, {v[1], v[0], v[1], 3'h2, v[0]});
      chk({pu[3:1], pd[3:1], wake}, 0);
    end
    @(posedge clk_sys_i);
    spi <= 1'b0;
    pdat <= 3'h5;
    ext_en <= 4'h0;
    @(negedge clk_sys_i);
    chk({doe[3:1], dout[3:1], so}, {3'h7, 3'h5, 3'h1});
    $display("test client spi done");
    final_report();
  end
endmodule : port_pin_function_mux_tb
